//--- dv/eebrw_chk.sv
`timescale 1ns/10ps
// pin sequencing checks on the host port
module eebrw_chk (
	// clock
	input wire logic clk,
	input wire logic rst,
	// user
	input wire logic req_valid,
	input wire logic req_ready,
	// pins
	input wire logic [eebrw_pkg::ADDR_W-1:0] mem_addr,
	input wire logic chip_sel_n,
	input wire logic out_drv_n,
	input wire logic wr_strobe_n,
	input wire logic erase_hv_en,
	input wire logic data_lines_oe
);
	int gap_reg;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// cycles since strobe was last low, saturating so the first write passes
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			gap_reg <= 2000;
		end else if (!wr_strobe_n) begin
			gap_reg <= 0;
		end else if (gap_reg < 2000) begin
			gap_reg <= gap_reg + 1;
		end
	end
	property p_rd; !chip_sel_n && !out_drv_n |-> wr_strobe_n; endproperty
	a_rd: assert property (p_rd) else $error("strobe low in read");
	property p_oe; !out_drv_n |-> !data_lines_oe; endproperty
	a_oe: assert property (p_oe) else $error("bus clash");
	property p_addr; $fell(chip_sel_n) |-> $stable(mem_addr); endproperty
	a_addr: assert property (p_addr) else $error("address moved at select");
	property p_wr; $fell(wr_strobe_n) |-> !chip_sel_n && out_drv_n && data_lines_oe; endproperty
	a_wr: assert property (p_wr) else $error("bad write combination");
	property p_pulse;
		$fell(wr_strobe_n) |-> data_lines_oe throughout (##[99:102] $rose(wr_strobe_n));
	endproperty
	a_pulse: assert property (p_pulse) else $error("strobe width");
	property p_gap; $fell(wr_strobe_n) |-> gap_reg > 1000; endproperty
	a_gap: assert property (p_gap) else $error("write too soon");
	property p_hv; erase_hv_en |-> chip_sel_n && wr_strobe_n && !data_lines_oe; endproperty
	a_hv: assert property (p_hv) else $error("erase pins");
	property p_busy; req_valid && req_ready |=> !req_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
endmodule

//--- dv/eebrw_dev.sv
`timescale 1ns/10ps
// device model; write time shortened so the run stays short
module eebrw_dev #(parameter int BUSY_NS = 30000) (
	// pins from host
	input wire logic [11:0] a,
	input wire logic cs_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic hv,
	input wire logic [7:0] d,
	// read drive
	output logic [7:0] q,
	output logic q_en
);
	logic [7:0] mem [4096];
	logic [11:0] wa;
	logic [7:0] wd = 8'h00;
	logic armed = 1'b0;
	logic busy = 1'b0;
	// later falling edge arms, and only in the write combination
	always @(negedge we_n or negedge cs_n)
		if (!we_n && !cs_n && oe_n && !hv) begin
			wa = a;
			armed = 1'b1;
		end
	// earlier rising edge takes data; erase, then program after the timer
	always @(posedge we_n or posedge cs_n)
		if (armed) begin
			armed = 1'b0;
			wd = d;
			busy = 1'b1;
			mem[wa] = 8'hff;
			#(BUSY_NS) mem[wa] = wd;
			busy = 1'b0;
		end
	// whole-array erase with select and strobe high
	always @(posedge hv)
		if (cs_n && we_n)
			foreach (mem[i])
				mem[i] = 8'hff;
	// transparent read, bit 7 inverted while busy whatever the address
	assign q_en = !cs_n && !oe_n && we_n && !hv;
	assign q = busy ? {~wd[7], wd[6:0]} : mem[a];
endmodule

//--- dv/testbench.sv
`timescale 1ns/10ps
bind eebrw_host eebrw_chk u_chk (.clk(clk), .rst(rst), .req_valid(req_valid),
	.req_ready(req_ready), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
	.out_drv_n(out_drv_n), .wr_strobe_n(wr_strobe_n), .erase_hv_en(erase_hv_en),
	.data_lines_oe(data_lines_oe));
// host controller against the device model
module testbench;
	logic clk = 0;
	logic rst = 1;
	logic req_valid = 0;
	logic req_ready, rsp_valid, cs_n, oe_n, we_n, hv, d_oe, q_en;
	eebrw_pkg::eebrw_req_t req = '0;
	eebrw_pkg::eebrw_rsp_t rsp, got;
	logic [eebrw_pkg::ADDR_W-1:0] a;
	logic [7:0] d_o, q, bus;
	logic [7:0] last = 8'h00;
	int n_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	int n_selects = 0;
	eebrw_host u_dut (.clk(clk), .rst(rst), .req(req), .req_valid(req_valid),
		.req_ready(req_ready), .rsp(rsp), .rsp_valid(rsp_valid), .mem_addr(a),
		.chip_sel_n(cs_n), .out_drv_n(oe_n), .wr_strobe_n(we_n), .erase_hv_en(hv),
		.data_lines_i(bus), .data_lines_o(d_o), .data_lines_oe(d_oe));
	eebrw_dev u_dev (.a(a), .cs_n(cs_n), .oe_n(oe_n), .we_n(we_n), .hv(hv), .d(bus),
		.q(q), .q_en(q_en));
	// released lines show the inverse of the last driven value, never a stale copy
	assign bus = d_oe ? d_o : q_en ? q : ~last;
	always @(bus)
		if (d_oe || q_en)
			last = bus;
	// select falls counted, so a write that needed no retry poll shows up
	always @(negedge cs_n) begin
		n_selects++;
	end
	// clock
	initial begin
		forever #5 clk = ~clk;
	end
	// hang guard, well above the few writes of this run
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_errors++;
			final_report;
		end
	end
	task cmp(input logic [8:0] g, input logic [8:0] e);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// one request, answer kept in got, then pins must be back at rest
	task automatic op(input logic [1:0] c, input logic [11:0] ad, input logic [7:0] dt);
		int n = 0;
		while (req_ready !== 1'b1)
			@(posedge clk) #1;
		req = '{c, ad, dt};
		req_valid = 1;
		@(posedge clk) #1;
		req_valid = 0;
		while (rsp_valid !== 1'b1 && n < 20000) begin
			@(posedge clk) #1;
			n++;
		end
		// a missing answer counts as a mismatch here
		cmp({8'h00, rsp_valid}, 9'h001);
		got = rsp;
		@(posedge clk) #1;
		cmp({4'h0, cs_n, oe_n, we_n, d_oe, hv}, 9'h01c);
	endtask
	task t_erase;
		op(eebrw_pkg::CMD_ERASE, 12'h000, 8'h00);
		op(eebrw_pkg::CMD_READ, 12'h0ff, 8'h00);
		cmp(got, {8'hff, 1'b0});
	endtask
	// both values of bit 7 polled, then neighbours must be untouched
	task t_write;
		n_selects = 0;
		op(eebrw_pkg::CMD_WRITE, 12'h0ff, 8'h5a);
		cmp(got, {8'h5a, 1'b0});
		cmp(9'(n_selects > 2), 9'h001);
		op(eebrw_pkg::CMD_READ, 12'h0ff, 8'h00);
		cmp(got, {8'h5a, 1'b0});
		n_selects = 0;
		op(eebrw_pkg::CMD_WRITE, 12'hfff, 8'ha5);
		cmp(got, {8'ha5, 1'b0});
		cmp(9'(n_selects > 2), 9'h001);
		op(eebrw_pkg::CMD_READ, 12'hfff, 8'h00);
		cmp(got, {8'ha5, 1'b0});
		op(eebrw_pkg::CMD_READ, 12'h0ff, 8'h00);
		cmp(got, {8'h5a, 1'b0});
		op(eebrw_pkg::CMD_READ, 12'h000, 8'h00);
		cmp(got, {8'hff, 1'b0});
	endtask
	task final_report;
		$display("errors %0d compared %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk);
		#1 rst = 0;
		t_erase;
		t_write;
		final_report;
	end
endmodule

//--- inc/eebrw_pkg.sv
package eebrw_pkg;
	// array shape: 4k x 8 covers the 2k part too
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int POLL_BIT = 7;
	// clock and pin timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETUP_NS = 100;
	localparam int SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_NS = 1000;
	localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_NS = 100;
	localparam int READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RECOVER_NS = 10000;
	localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// internal_write_duration, 5 ms, polling gives up after twice that
	localparam int WRITE_DUR_US = 5000;
	localparam int POLL_LIMIT_CYC = 2 * WRITE_DUR_US * 1000 / CLK_PERIOD_NS;
	localparam int CNT_W = 24;
	// command codes
	localparam logic [1:0] CMD_READ = 2'h0;
	localparam logic [1:0] CMD_WRITE = 2'h1;
	localparam logic [1:0] CMD_ERASE = 2'h2;

	typedef struct packed {
		logic [1:0] op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} eebrw_req_t;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic timeout;
	} eebrw_rsp_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_STROBE = 3'b010,
		ST_READ = 3'b011,
		ST_RECOVER = 3'b100,
		ST_POLL = 3'b101,
		ST_HOLD = 3'b110
	} eebrw_state_t;
endpackage

//--- src/eebrw_host.sv
`timescale 1ns/10ps
// Contract
// - drive address first, then lower chip select once address is stable
// - keep write strobe high through every read
// - hold write strobe low only for the minimum pulse, then release
// - poll by reading and comparing bit seven with the written value
// - polling reads use ordinary read timing; address is don't care
// - whole-array erase: chip select high, strobe high, output drive at high voltage
module eebrw_host (
	input wire logic clk,
	input wire logic rst,
	// user command side
	input wire eebrw_pkg::eebrw_req_t req,
	input wire logic req_valid,
	output logic req_ready,
	output eebrw_pkg::eebrw_rsp_t rsp,
	output logic rsp_valid,
	// device pins
	output logic [eebrw_pkg::ADDR_W-1:0] mem_addr,
	output logic chip_sel_n,
	output logic out_drv_n,
	output logic wr_strobe_n,
	output logic erase_hv_en,
	input wire logic [eebrw_pkg::DATA_W-1:0] data_lines_i,
	output logic [eebrw_pkg::DATA_W-1:0] data_lines_o,
	output logic data_lines_oe
);
	// sequencer state and its timers; the poll budget runs across every retry
	eebrw_pkg::eebrw_state_t state_reg;
	logic [eebrw_pkg::CNT_W-1:0] cnt_reg;
	logic [eebrw_pkg::CNT_W-1:0] poll_cnt_reg;
	// request held for the whole transfer; bit seven kept for polling
	logic [1:0] op_reg;
	logic want_bit_reg;
	logic [eebrw_pkg::DATA_W-1:0] data_sync;

	// data pins come from another timing domain
	eebrw_sync #(.W(eebrw_pkg::DATA_W)) u_sync (
		.clk(clk),
		.rst(rst),
		.d(data_lines_i),
		.q(data_sync)
	);

	// phase timer expiry; every wait below is a count down to zero
	wire logic cnt_done = (cnt_reg == '0);

	// sequencer driving the pins
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= eebrw_pkg::ST_IDLE;
			cnt_reg <= '0;
			poll_cnt_reg <= '0;
			op_reg <= eebrw_pkg::CMD_READ;
			want_bit_reg <= 1'b0;
			// user side: not ready until the first idle cycle
			req_ready <= 1'b0;
			rsp <= '0;
			rsp_valid <= 1'b0;
			// pins at rest: deselected, no strobe, no high voltage, bus released
			mem_addr <= '0;
			chip_sel_n <= 1'b1;
			out_drv_n <= 1'b1;
			wr_strobe_n <= 1'b1;
			erase_hv_en <= 1'b0;
			data_lines_o <= '0;
			data_lines_oe <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			unique case (state_reg)
				eebrw_pkg::ST_IDLE: begin
					// idle is standby: chip deselected, bus floating
					chip_sel_n <= 1'b1;
					out_drv_n <= 1'b1;
					wr_strobe_n <= 1'b1;
					data_lines_oe <= 1'b0;
					req_ready <= 1'b1;
					if (req_valid && req_ready) begin
						req_ready <= 1'b0;
						op_reg <= req.op;
						mem_addr <= req.addr; // address goes out alone first
						data_lines_o <= req.data;
						// bit seven of the write data is what a finished poll must show
						want_bit_reg <= req.data[eebrw_pkg::POLL_BIT];
						cnt_reg <= eebrw_pkg::CNT_W'(eebrw_pkg::SETUP_CYC);
						state_reg <= eebrw_pkg::ST_SETUP;
					end
				end
				eebrw_pkg::ST_SETUP: begin
					if (cnt_done) begin
						unique case (op_reg)
							eebrw_pkg::CMD_WRITE: begin
								// write combination only: select low, drive high
								chip_sel_n <= 1'b0;
								out_drv_n <= 1'b1;
								wr_strobe_n <= 1'b0;
								data_lines_oe <= 1'b1;
								cnt_reg <= eebrw_pkg::CNT_W'(eebrw_pkg::STROBE_CYC);
								state_reg <= eebrw_pkg::ST_STROBE;
							end
							eebrw_pkg::CMD_ERASE: begin
								// select and strobe stay high, drive pin at high voltage
								erase_hv_en <= 1'b1;
								cnt_reg <= eebrw_pkg::CNT_W'(eebrw_pkg::RECOVER_CYC);
								state_reg <= eebrw_pkg::ST_HOLD;
							end
							default: begin
								// read: strobe held high throughout
								chip_sel_n <= 1'b0;
								out_drv_n <= 1'b0;
								wr_strobe_n <= 1'b1;
								cnt_reg <= eebrw_pkg::CNT_W'(eebrw_pkg::READ_CYC);
								state_reg <= eebrw_pkg::ST_READ;
							end
						endcase
					end else begin
						// address settles on the pins before select falls
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				eebrw_pkg::ST_STROBE: begin
					// data stays on the bus until after the strobe has risen
					if (cnt_done) begin
						// short pulse; device times the rest itself
						wr_strobe_n <= 1'b1;
						cnt_reg <= eebrw_pkg::CNT_W'(eebrw_pkg::RECOVER_CYC);
						poll_cnt_reg <= eebrw_pkg::CNT_W'(eebrw_pkg::POLL_LIMIT_CYC);
						state_reg <= eebrw_pkg::ST_RECOVER;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				eebrw_pkg::ST_RECOVER: begin
					// release bus, then open a polling read
					chip_sel_n <= 1'b1;
					data_lines_oe <= 1'b0;
					if (poll_cnt_reg != '0) begin
						poll_cnt_reg <= poll_cnt_reg - 1'b1;
					end
					if (cnt_done) begin
						// address is left as written; polling ignores it anyway
						chip_sel_n <= 1'b0;
						out_drv_n <= 1'b0;
						cnt_reg <= eebrw_pkg::CNT_W'(eebrw_pkg::READ_CYC);
						state_reg <= eebrw_pkg::ST_POLL;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				eebrw_pkg::ST_POLL: begin
					// the budget keeps running through the read itself
					if (poll_cnt_reg != '0) begin
						poll_cnt_reg <= poll_cnt_reg - 1'b1;
					end
					if (cnt_done) begin
						// done when bit seven matches what was written or the poll budget has run out
						if (data_sync[eebrw_pkg::POLL_BIT] == want_bit_reg
								|| poll_cnt_reg == '0) begin
							rsp.data <= data_sync;
							rsp.timeout <= (poll_cnt_reg == '0);
							rsp_valid <= 1'b1;
							chip_sel_n <= 1'b1;
							out_drv_n <= 1'b1;
							state_reg <= eebrw_pkg::ST_IDLE;
						end else begin
							// still inverted: drop select and read again
							chip_sel_n <= 1'b1;
							out_drv_n <= 1'b1;
							cnt_reg <= eebrw_pkg::CNT_W'(eebrw_pkg::SETUP_CYC);
							state_reg <= eebrw_pkg::ST_RECOVER;
						end
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				eebrw_pkg::ST_READ: begin
					// wait is READ_CYC, the access time alone, with no cycles added for synchroniser latency
					if (cnt_done) begin
						rsp.data <= data_sync;
						rsp.timeout <= 1'b0;
						rsp_valid <= 1'b1;
						chip_sel_n <= 1'b1;
						out_drv_n <= 1'b1;
						state_reg <= eebrw_pkg::ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				eebrw_pkg::ST_HOLD: begin
					// high-voltage erase pulse, held by a plain count
					if (cnt_done) begin
						// no completion status exists for erase, so report at once
						erase_hv_en <= 1'b0;
						rsp.data <= '0;
						rsp.timeout <= 1'b0;
						rsp_valid <= 1'b1;
						state_reg <= eebrw_pkg::ST_IDLE;
					end else begin
						cnt_reg <= cnt_reg - 1'b1;
					end
				end
				default: begin
					// illegal state code: back to standby
					state_reg <= eebrw_pkg::ST_IDLE;
				end
			endcase
		end
	end
endmodule

//--- src/eebrw_sync.sv
`timescale 1ns/10ps
// three-stage input synchroniser; a change counts once stages two and three agree
module eebrw_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// stage one feeds stage two only
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q <= '0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q <= s3_reg;
			end
		end
	end
endmodule
